// ---- src/taec_top.sv ----
// Three-axis encoder counter card: address decode, sampling, timer, interrupt
`timescale 1ns/1ns
`include "taec_defs.svh"
//
// Notes on behaviour
// - Three independent 24-bit up/down counters
// - Each axis mode chosen separately by software
// - Quadrature gives one, two or four counts
// - Axis one carry or borrow clocks axis two
// - Four-stage filter sampled at 8, 4, 2 MHz
// - Handles 1 MHz quadrature, 1 MHz pulses
// - Timer period is base times multiplier, repeating
// - Interrupt on input, overflow or timer
// - Fixed source numbering, one source at once
// - Five filtered digital inputs, each can interrupt
// - Answers sixteen consecutive I/O addresses only
// - A9..A4 match switches, open is one
// - Request driven onto one jumpered host line
// - Source seven is timer or second input
// - Request rising edge marks the event
// - Pulse mode: B high counts down
//
module taec_top #(
  parameter int TB_10HZ_CYC  = `TAEC_CLK_HZ / `TAEC_TB_10HZ_HZ,
  parameter int TB_1KHZ_CYC  = `TAEC_CLK_HZ / `TAEC_TB_1KHZ_HZ,
  parameter int TB_10KHZ_CYC = `TAEC_CLK_HZ / `TAEC_TB_10KHZ_HZ
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RESET_N_I,
  input  wire logic [9:0]                  ISA_ADDR_I,
  input  wire logic                        ISA_AEN_I,
  input  wire logic                        ISA_IOR_N_I,
  input  wire logic                        ISA_IOW_N_I,
  input  wire logic [5:0]                  BASE_ADDRESS_SWITCH_I,
  input  wire logic [2:0]                  ENC_A_I,
  input  wire logic [2:0]                  ENC_B_I,
  input  wire logic [2:0]                  INDEX_INPUT_I,
  input  wire logic                        DIGITAL_INPUT_ZERO_I,
  input  wire logic                        DIGITAL_INPUT_ONE_I,
  input  wire taec_pkg::taec_mode_t [2:0]  AXIS_MODE_I,
  input  wire taec_pkg::taec_mult_t [2:0]  AXIS_MULT_I,
  input  wire taec_pkg::taec_samp_t        SAMPLE_RATE_I,
  input  wire logic                        CASCADE_I,
  input  wire logic                        TIMER_EN_I,
  input  wire taec_pkg::taec_tbase_t       TIMER_BASE_I,
  input  wire logic [7:0]                  TIMER_MULT_I,
  input  wire logic                        SHARED_SRC_TIMER_I,
  input  wire logic [2:0]                  IRQ_SOURCE_SEL_I,
  input  wire logic [2:0]                  IRQ_LEVEL_JUMPER_I,
  output logic                             CARD_SELECT_O,
  output logic                             CARD_READ_O,
  output logic                             CARD_WRITE_O,
  output logic [3:0]                       REG_INDEX_O,
  output logic [71:0]                      COUNT_O,
  output logic [2:0]                       OVERFLOW_O,
  output logic [2:0]                       UNDERFLOW_O,
  output logic [2:0]                       INDEX_EVENT_O,
  output logic [1:0]                       DIGITAL_INPUT_O,
  output logic                             TIMER_EVENT_O,
  output logic [7:0]                       IRQ_LINES_O
);
  import taec_pkg::*;
  taec_top_st_t r_ff, nxt_r;
  logic [5:0]  samp_lim;
  logic [23:0] tb_lim;
  logic [1:0]  di_raw;
  logic [7:0]  src;
  logic        pick;
  logic        hit;

  // ************************************************************
  // Axes
  // ************************************************************
  // Filters run off the shared sample enable, so all axes see one rate
  for (genvar i = 0; i < 3; i++) begin : g_axis
    taec_axis u_axis (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .samp_en_i (r_ff.samp_en),
      .a_i       (ENC_A_I[i]),
      .b_i       (ENC_B_I[i]),
      .z_i       (INDEX_INPUT_I[i]),
      .mode_i    (AXIS_MODE_I[i]),
      .mult_i    (AXIS_MULT_I[i]),
      .casc_en_i ((i == 1) ? CASCADE_I : 1'b0),
      .casc_up_i (OVERFLOW_O[0]),
      .casc_dn_i (UNDERFLOW_O[0]),
      .cnt_o     (COUNT_O[24*i +: 24]),
      .ovf_o     (OVERFLOW_O[i]),
      .unf_o     (UNDERFLOW_O[i]),
      .idx_o     (INDEX_EVENT_O[i])
    );
  end

  // ************************************************************
  // Rate selection and interrupt sources
  // ************************************************************
  // At 8 MHz sampling the filter settles in 0.5 us, fast enough for 1 MHz quadrature edges
  assign samp_lim = (SAMPLE_RATE_I == samp_4m) ? 6'(`TAEC_SAMP_4M_CYC - 1) :
                    (SAMPLE_RATE_I == samp_2m) ? 6'(`TAEC_SAMP_2M_CYC - 1) :
                    6'(`TAEC_SAMP_8M_CYC - 1);
  assign tb_lim = (TIMER_BASE_I == tb_1khz)  ? 24'(TB_1KHZ_CYC - 1) :
                  (TIMER_BASE_I == tb_10khz) ? 24'(TB_10KHZ_CYC - 1) :
                  24'(TB_10HZ_CYC - 1);
  assign di_raw = {DIGITAL_INPUT_ONE_I, DIGITAL_INPUT_ZERO_I};
  assign src = {SHARED_SRC_TIMER_I ? r_ff.tm_ev : r_ff.di_rise[1],
                r_ff.di_rise[0], INDEX_EVENT_O, OVERFLOW_O | UNDERFLOW_O};
  assign pick = src[IRQ_SOURCE_SEL_I];
  assign hit = !ISA_AEN_I && (ISA_ADDR_I[9:4] == BASE_ADDRESS_SWITCH_I) &&
               (!ISA_IOR_N_I || !ISA_IOW_N_I);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.samp_en = 1'b0;
    nxt_r.tm_ev = 1'b0;
    if (r_ff.samp_div == samp_lim) begin
      nxt_r.samp_div = 6'h00;
      nxt_r.samp_en = 1'b1;
    end else begin
      nxt_r.samp_div = r_ff.samp_div + 6'h01;
    end
    for (int k = 0; k < 2; k++) begin
      if (r_ff.samp_en) begin
        nxt_r.di_sh[k] = {r_ff.di_sh[k][`TAEC_FILT_STAGES-2:0], di_raw[k]};
        if (&nxt_r.di_sh[k]) begin
          nxt_r.di_f[k] = 1'b1;
        end else if (~|nxt_r.di_sh[k]) begin
          nxt_r.di_f[k] = 1'b0;
        end
      end
    end
    nxt_r.di_rise = nxt_r.di_f & ~r_ff.di_f;
    // A multiplier of zero stops the timer rather than giving a 256 period
    if (!TIMER_EN_I || TIMER_MULT_I == 8'h00) begin
      nxt_r.tb_cnt = 24'h000000;
      nxt_r.tm_cnt = 8'h00;
    end else if (r_ff.tb_cnt == tb_lim) begin
      nxt_r.tb_cnt = 24'h000000;
      if (r_ff.tm_cnt == TIMER_MULT_I - 8'h01) begin
        nxt_r.tm_cnt = 8'h00;
        nxt_r.tm_ev = 1'b1;
      end else begin
        nxt_r.tm_cnt = r_ff.tm_cnt + 8'h01;
      end
    end else begin
      nxt_r.tb_cnt = r_ff.tb_cnt + 24'h000001;
    end
    // Request is stretched so the host controller sees a clean rising edge
    if (pick) begin
      nxt_r.irq_req = 1'b1;
      nxt_r.hold = 4'(`TAEC_IRQ_HOLD_CYC - 1);
    end else if (r_ff.hold != 4'h0) begin
      nxt_r.hold = r_ff.hold - 4'h1;
    end else begin
      nxt_r.irq_req = 1'b0;
    end
    nxt_r.irq_lines = nxt_r.irq_req ? (8'h01 << IRQ_LEVEL_JUMPER_I) : 8'h00;
    nxt_r.sel = hit;
    nxt_r.rd = hit && !ISA_IOR_N_I;
    nxt_r.wr = hit && !ISA_IOW_N_I;
    nxt_r.reg_idx = hit ? ISA_ADDR_I[3:0] : r_ff.reg_idx;
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign CARD_SELECT_O = r_ff.sel;
  assign CARD_READ_O = r_ff.rd;
  assign CARD_WRITE_O = r_ff.wr;
  assign REG_INDEX_O = r_ff.reg_idx;
  assign DIGITAL_INPUT_O = r_ff.di_f;
  assign TIMER_EVENT_O = r_ff.tm_ev;
  assign IRQ_LINES_O = r_ff.irq_lines;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_source_event;
    pick;
  endsequence
  sequence s_request_held;
    r_ff.irq_req [*8];
  endsequence
  sequence s_carry_in;
    CASCADE_I && OVERFLOW_O[0];
  endsequence

  a_decode_window: assert property (CARD_SELECT_O == ($past(ISA_ADDR_I[9:4]) == $past(BASE_ADDRESS_SWITCH_I)
    && !$past(ISA_AEN_I) && (!$past(ISA_IOR_N_I) || !$past(ISA_IOW_N_I))))
    else $error("card select does not match address window");
  a_irq_one_line: assert property ($onehot0(IRQ_LINES_O) &&
    ((IRQ_LINES_O & ~(8'h01 << $past(IRQ_LEVEL_JUMPER_I))) == 8'h00))
    else $error("request driven on an unselected line");
  a_irq_stretch: assert property (s_source_event |=> s_request_held)
    else $error("selected source did not raise a held request");
  a_timer_period: assert property (r_ff.tm_ev |-> $past(r_ff.tm_cnt) == 8'($past(TIMER_MULT_I) - 8'h01)
    && $past(r_ff.tb_cnt) == $past(tb_lim))
    else $error("timer fired before base times multiplier");
  a_cascade_carry: assert property (s_carry_in |=> COUNT_O[47:24] == 24'($past(COUNT_O[47:24]) + 24'h000001))
    else $error("cascaded axis missed the carry");
endmodule

// ---- src/taec_defs.svh ----
// Constants for the three-axis encoder counter card
`ifndef TAEC_DEFS_SVH
`define TAEC_DEFS_SVH
`define TAEC_CLK_HZ 125000000
`define TAEC_SAMP_8M_HZ 8000000
`define TAEC_SAMP_4M_HZ 4000000
`define TAEC_SAMP_2M_HZ 2000000
`define TAEC_SAMP_8M_CYC (`TAEC_CLK_HZ / `TAEC_SAMP_8M_HZ)
`define TAEC_SAMP_4M_CYC (`TAEC_CLK_HZ / `TAEC_SAMP_4M_HZ)
`define TAEC_SAMP_2M_CYC (`TAEC_CLK_HZ / `TAEC_SAMP_2M_HZ)
`define TAEC_TB_10HZ_HZ 10
`define TAEC_TB_1KHZ_HZ 1000
`define TAEC_TB_10KHZ_HZ 10000
`define TAEC_FILT_STAGES 4
`define TAEC_CNT_WIDTH 24
`define TAEC_CNT_MAX 24'hffffff
`define TAEC_IRQ_HOLD_CYC 8
`endif

// ---- src/taec_pkg.sv ----
// Types for the three-axis encoder counter card
`include "taec_defs.svh"
package taec_pkg;
  typedef enum logic [1:0] {mode_off, mode_quad, mode_pdir, mode_two_pulse} taec_mode_t;
  typedef enum logic [1:0] {single_count_per_cycle, double_count_per_cycle, quad_count_per_cycle} taec_mult_t;
  typedef enum logic [1:0] {samp_8m, samp_4m, samp_2m} taec_samp_t;
  typedef enum logic [1:0] {tb_10hz, tb_1khz, tb_10khz} taec_tbase_t;
  typedef struct packed {
    logic [`TAEC_FILT_STAGES-1:0] sh_a;
    logic [`TAEC_FILT_STAGES-1:0] sh_b;
    logic [`TAEC_FILT_STAGES-1:0] sh_z;
    logic                         fa;
    logic                         fb;
    logic                         fz;
    logic [`TAEC_CNT_WIDTH-1:0]   cnt;
    logic                         ovf;
    logic                         unf;
    logic                         idx;
  } taec_axis_st_t;
  typedef struct packed {
    logic [5:0]                        samp_div;
    logic                              samp_en;
    logic [1:0][`TAEC_FILT_STAGES-1:0] di_sh;
    logic [1:0]                        di_f;
    logic [1:0]                        di_rise;
    logic [23:0]                       tb_cnt;
    logic [7:0]                        tm_cnt;
    logic                              tm_ev;
    logic [3:0]                        hold;
    logic                              irq_req;
    logic [7:0]                        irq_lines;
    logic                              sel;
    logic                              rd;
    logic                              wr;
    logic [3:0]                        reg_idx;
  } taec_top_st_t;
endpackage

// ---- src/taec_axis.sv ----
// One counter axis: input filters, decoder and 24-bit counter
`timescale 1ns/1ns
`include "taec_defs.svh"
module taec_axis (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       samp_en_i,
  input  wire logic                       a_i,
  input  wire logic                       b_i,
  input  wire logic                       z_i,
  input  wire taec_pkg::taec_mode_t       mode_i,
  input  wire taec_pkg::taec_mult_t       mult_i,
  input  wire logic                       casc_en_i,
  input  wire logic                       casc_up_i,
  input  wire logic                       casc_dn_i,
  output logic [`TAEC_CNT_WIDTH-1:0]      cnt_o,
  output logic                            ovf_o,
  output logic                            unf_o,
  output logic                            idx_o
);
  import taec_pkg::*;
  taec_axis_st_t r_ff, nxt_r;

  // Level changes only once all stages agree
  function automatic logic filt(input logic [`TAEC_FILT_STAGES-1:0] sh, input logic prev);
    filt = (&sh) ? 1'b1 : ((~|sh) ? 1'b0 : prev);
  endfunction

  always_comb begin
    logic up;
    logic dn;
    logic ea;
    logic eb;
    up = 1'b0;
    dn = 1'b0;
    ea = 1'b0;
    eb = 1'b0;
    nxt_r = r_ff;
    nxt_r.ovf = 1'b0;
    nxt_r.unf = 1'b0;
    if (samp_en_i) begin
      nxt_r.sh_a = {r_ff.sh_a[`TAEC_FILT_STAGES-2:0], a_i};
      nxt_r.sh_b = {r_ff.sh_b[`TAEC_FILT_STAGES-2:0], b_i};
      nxt_r.sh_z = {r_ff.sh_z[`TAEC_FILT_STAGES-2:0], z_i};
      nxt_r.fa = filt(nxt_r.sh_a, r_ff.fa);
      nxt_r.fb = filt(nxt_r.sh_b, r_ff.fb);
      nxt_r.fz = filt(nxt_r.sh_z, r_ff.fz);
    end
    ea = nxt_r.fa ^ r_ff.fa;
    eb = nxt_r.fb ^ r_ff.fb;
    unique case (mode_i)
      mode_off: ;
      mode_quad: begin
        if (ea && !eb && (mult_i == double_count_per_cycle || mult_i == quad_count_per_cycle ||
            (mult_i == single_count_per_cycle && nxt_r.fa))) begin
          up = nxt_r.fa ^ nxt_r.fb;
          dn = ~up;
        end else if (eb && !ea && mult_i == quad_count_per_cycle) begin
          up = ~(nxt_r.fa ^ nxt_r.fb);
          dn = ~up;
        end
      end
      mode_pdir: begin
        if (nxt_r.fa && !r_ff.fa) begin
          dn = nxt_r.fb;
          up = ~nxt_r.fb;
        end
      end
      mode_two_pulse: begin
        up = eb & nxt_r.fb & ~(ea & nxt_r.fa);
        dn = ea & nxt_r.fa & ~(eb & nxt_r.fb);
      end
    endcase
    // Cascaded axis counts only the carry and borrow of its neighbour
    if (casc_en_i) begin
      up = casc_up_i;
      dn = casc_dn_i;
    end
    if (up) begin
      nxt_r.cnt = r_ff.cnt + 24'h000001;
      nxt_r.ovf = (r_ff.cnt == `TAEC_CNT_MAX);
    end else if (dn) begin
      nxt_r.cnt = r_ff.cnt - 24'h000001;
      nxt_r.unf = (r_ff.cnt == 24'h000000);
    end
    nxt_r.idx = nxt_r.fz & ~r_ff.fz;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cnt_o = r_ff.cnt;
  assign ovf_o = r_ff.ovf;
  assign unf_o = r_ff.unf;
  assign idx_o = r_ff.idx;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_wrap_up: assert property (r_ff.ovf |-> r_ff.cnt == 24'h000000 && $past(r_ff.cnt) == `TAEC_CNT_MAX)
    else $error("overflow pulse without wrap to zero");
  a_wrap_down: assert property (r_ff.unf |-> r_ff.cnt == `TAEC_CNT_MAX && $past(r_ff.cnt) == 24'h000000)
    else $error("underflow pulse without wrap to max");
  a_filter_agree: assert property ($changed(r_ff.fa) |-> r_ff.sh_a == {`TAEC_FILT_STAGES{r_ff.fa}})
    else $error("filtered phase A changed before all stages agreed");
  a_pdir_up: assert property ($past(mode_i) == mode_pdir && !$past(casc_en_i) && $rose(r_ff.fa) && !r_ff.fb
    |-> r_ff.cnt == 24'($past(r_ff.cnt) + 24'h000001))
    else $error("pulse with direction low did not count up");
  a_quad_single: assert property ($past(mode_i) == mode_quad && $past(mult_i) == single_count_per_cycle &&
    !$past(casc_en_i) && $fell(r_ff.fa) |-> $stable(r_ff.cnt))
    else $error("single count mode counted on falling phase A");
  a_mode_off: assert property ($past(mode_i) == mode_off && !$past(casc_en_i) |-> $stable(r_ff.cnt))
    else $error("disabled axis changed its count");
endmodule

// ---- sim/taec_enc_model.sv ----
// Encoder model: quadrature or pulse stimulus on request
`timescale 1ns/1ns
module taec_enc_model #(
  parameter int GAP = 300
) (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [5:0] n_i,
  input  wire logic       dir_i,
  input  wire logic       pulse_i,
  output logic            a_o,
  output logic            b_o
);
  int left;
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end
  // Edges spaced GAP clocks so each level outlasts four of the slowest samples
  always begin
    @(posedge clk_i);
    if (go_i) begin
      left = n_i;
      if (pulse_i) begin
        b_o <= dir_i;
      end
      while (left > 0) begin
        repeat (GAP) @(posedge clk_i);
        left = left - 1;
        if (pulse_i) begin
          a_o <= ~a_o;
        end else if ((a_o == b_o) ^ dir_i) begin
          a_o <= ~a_o;
        end else begin
          b_o <= ~b_o;
        end
      end
      repeat (GAP) @(posedge clk_i);
      b_o <= 1'b0;
    end
  end
endmodule

// ---- sim/test_taec_top.sv ----
// Self-checking bench for the three-axis encoder counter card
`timescale 1ns/1ns
module test_taec_top;
  import taec_pkg::*;
  logic             clk, rst_n, aen, ior_n, iow_n, casc, tmr_en, shared, dir, pulse;
  logic [9:0]       addr;
  logic [5:0]       sw, n;
  logic [2:0]       enc_a, enc_b, go, sel, jmp, ovf, unf, iev;
  logic [4:0]       din;
  taec_mode_t [2:0] mode;
  taec_mult_t [2:0] mult;
  taec_samp_t       rate;
  taec_tbase_t      tbase;
  logic [7:0]       tmr_mult, irq, ipat;
  logic             sel_o, rd_o, wr_o, tev;
  logic [3:0]       idx_o;
  logic [71:0]      cnt;
  logic [1:0]       di_o;
  logic [25:0]      nt;
  logic [25:0]      cq[$];
  logic [8:0]       wq[$];
  logic [7:0]       iq[$];
  int               tq[$];
  logic [23:0]      ex[3] = '{24'h0, 24'h0, 24'h0};
  int               bc[3] = '{20, 10, 5};
  int               bad_count = 0, num_checks = 0, cyc = 0, tlast = -1, irun = 0, j;
  integer           seed = 32'hb64f;
  logic [24:0]      tab[6] = '{{6'h20, 10'h205, 2'b01, 7'h65}, {6'h20, 10'h20f, 2'b00, 7'h5f},
                               {6'h20, 10'h215, 2'b01, 7'h0f}, {6'h20, 10'h203, 2'b11, 7'h0f},
                               {6'h3f, 10'h3f0, 2'b01, 7'h60}, {6'h3f, 10'h200, 2'b01, 7'h00}};
  taec_top #(.TB_10HZ_CYC(20), .TB_1KHZ_CYC(10), .TB_10KHZ_CYC(5)) dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .ISA_ADDR_I(addr), .ISA_AEN_I(aen), .ISA_IOR_N_I(ior_n),
    .ISA_IOW_N_I(iow_n), .BASE_ADDRESS_SWITCH_I(sw), .ENC_A_I(enc_a), .ENC_B_I(enc_b),
    .INDEX_INPUT_I(din[2:0]), .DIGITAL_INPUT_ZERO_I(din[3]), .DIGITAL_INPUT_ONE_I(din[4]),
    .AXIS_MODE_I(mode), .AXIS_MULT_I(mult), .SAMPLE_RATE_I(rate), .CASCADE_I(casc), .TIMER_EN_I(tmr_en),
    .TIMER_BASE_I(tbase), .TIMER_MULT_I(tmr_mult), .SHARED_SRC_TIMER_I(shared), .IRQ_SOURCE_SEL_I(sel),
    .IRQ_LEVEL_JUMPER_I(jmp), .CARD_SELECT_O(sel_o), .CARD_READ_O(rd_o), .CARD_WRITE_O(wr_o),
    .REG_INDEX_O(idx_o), .COUNT_O(cnt), .OVERFLOW_O(ovf), .UNDERFLOW_O(unf), .INDEX_EVENT_O(iev),
    .DIGITAL_INPUT_O(di_o), .TIMER_EVENT_O(tev), .IRQ_LINES_O(irq)
  );
  taec_enc_model enc[2:0] (.clk_i(clk), .go_i(go), .n_i(n), .dir_i(dir), .pulse_i(pulse), .a_o(enc_a), .b_o(enc_b));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic final_report;
    bad_count += cq.size() + wq.size() + iq.size() + tq.size();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic io(input logic [24:0] t);
    @(posedge clk);
    {sw, addr, aen} <= t[24:8];
    ior_n <= ~t[7];
    iow_n <= t[7];
    @(posedge clk);
    cq.push_back({2'd3, 17'h0, t[6:0]});
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    {addr, aen} <= 11'($unsigned($random(seed)));
    @(posedge clk);
    cq.push_back({2'd3, 20'h0, t[3:0]});
  endtask
  task automatic step(input logic [2:0] g, input logic [5:0] k, input logic d, input logic p);
    @(posedge clk);
    go <= g;
    n <= k;
    dir <= d;
    pulse <= p;
    @(posedge clk);
    go <= 3'b000;
    repeat (300 * (k + 2)) @(posedge clk);
  endtask
  task automatic cnts;
    for (int i = 0; i < 3; i++) cq.push_back({2'(i), ex[i]});
  endtask
  task automatic drain;
    int w;
    w = 0;
    while ((iq.size() + tq.size() + wq.size()) > 0 && w < 20000) begin
      @(posedge clk);
      w++;
    end
  endtask
  // ****
  // Monitor: pulses, request runs, timer gaps
  // ****
  always @(posedge clk) begin
    cyc++;
    if (cyc > 100000) begin
      bad_count++;
      final_report();
    end
    if ((ovf | unf | iev) != 3'h0)
      chk({15'h0, iev, ovf, unf}, (wq.size() > 0) ? {15'h0, wq.pop_front()} : 24'h0);
    if (!tmr_en) begin
      tlast = -1;
    end else if (tev) begin
      if (tlast >= 0 && tq.size() > 0) chk(24'(cyc - tlast), 24'(tq.pop_front()));
      tlast = cyc;
    end
    if (irq != 8'h00) begin
      if (irun == 0) ipat = irq;
      if (irq !== ipat) ipat = 8'hxx;
      irun++;
    end else if (irun != 0) begin
      chk({8'h0, ipat, 8'(irun)}, (iq.size() > 0) ? {8'h0, iq.pop_front(), 8'd8} : 24'h0);
      irun = 0;
    end
  end
  always @(negedge clk) begin
    while (cq.size() > 0) begin
      nt = cq.pop_front();
      if (nt[25:24] == 2'd3) chk({15'h0, di_o, sel_o, rd_o, wr_o, idx_o}, nt[23:0]);
      else chk(cnt[24*nt[25:24] +: 24], nt[23:0]);
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {rst_n, aen, casc, tmr_en, dir, pulse, go, din, addr, n} = '0;
    {ior_n, iow_n, shared} = 3'b111;
    {sw, sel, jmp, tmr_mult} = {6'h20, 3'd1, 3'd3, 8'h03};
    mode = {mode_off, mode_off, mode_off};
    mult = {single_count_per_cycle, single_count_per_cycle, single_count_per_cycle};
    rate = samp_8m;
    tbase = tb_10khz;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cnts();
    foreach (tab[i]) io(tab[i]);
    // Borrow then carry through the cascade, source 0 raising the request
    mode[0] <= mode_pdir;
    mode[1] <= mode_quad;
    casc <= 1'b1;
    mult[1] <= taec_mult_t'($unsigned($random(seed)) % 3);
    sel <= 3'd0;
    wq.push_back(9'h001); wq.push_back(9'h002); iq.push_back(8'h08);
    step(3'b001, 6'd2, 1'b1, 1'b1);
    ex[0] = 24'hffffff; ex[1] = 24'hffffff; cnts();
    wq.push_back(9'h008); wq.push_back(9'h010); iq.push_back(8'h08);
    step(3'b001, 6'd2, 1'b0, 1'b1);
    ex[0] = 24'h0; ex[1] = 24'h0; cnts();
    casc <= 1'b0;
    mode[0] <= mode_quad;
    mode[1] <= mode_off;
    for (int m = 0; m < 3; m++) begin
      mult[0] <= taec_mult_t'(m);
      rate <= taec_samp_t'(m);
      for (int d = 0; d < 2; d++) begin
        step(3'b011, 6'd8, d[0], 1'b0);
        ex[0] = d ? ex[0] - (24'd8 >> (2 - m)) : ex[0] + (24'd8 >> (2 - m));
        cnts();
      end
    end
    rate <= samp_8m;
    mode[2] <= mode_pdir;
    mult[2] <= taec_mult_t'($unsigned($random(seed)) % 3);
    j = 2 * (1 + ($unsigned($random(seed)) % 8));
    step(3'b100, 6'(j), 1'b0, 1'b1);
    mode[2] <= mode_two_pulse;
    step(3'b100, 6'd2, 1'b0, 1'b1);
    ex[2] = 24'(j / 2 - 1); cnts();
    // A pulse under four samples must not raise the request
    sel <= 3'd3;
    din <= 5'h01;
    repeat (20) @(posedge clk);
    din <= 5'h00;
    repeat (300) @(posedge clk);
    {tmr_en, shared} <= 2'b10;
    for (int s = 3; s < 8; s++) begin
      j = $unsigned($random(seed)) % 8;
      @(posedge clk);
      sel <= 3'(s);
      jmp <= 3'(j);
      iq.push_back(8'h01 << j);
      if (s < 6) wq.push_back(9'h040 << (s - 3));
      din <= 5'h01 << (s - 3);
      repeat (300) @(posedge clk);
      cq.push_back({2'd3, 15'h0, s == 7, s == 6, 7'h00});
      din <= 5'h00;
      repeat (300) @(posedge clk);
      drain();
    end
    {sel, shared} <= {3'd1, 1'b1};
    for (int b = 0; b < 3; b++) begin
      j = (b == 0) ? 255 : 1 + ($unsigned($random(seed)) % 255);
      @(posedge clk);
      tmr_en <= 1'b0;
      @(posedge clk);
      {tbase, tmr_mult, tmr_en} <= {taec_tbase_t'(b), 8'(j), 1'b1};
      tq.push_back(bc[b] * j); tq.push_back(bc[b] * j);
      drain();
    end
    // Multiplier zero stops the timer: no request may follow
    tmr_mult <= 8'h00;
    @(posedge clk);
    sel <= 3'd7;
    repeat (300) @(posedge clk);
    sel <= 3'd1;
    {tbase, tmr_mult} <= {tb_10khz, 8'h03};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {jmp, sel} <= {3'(k), 3'd7};
      iq.push_back(8'h01 << k);
      drain();
      sel <= 3'd1;
    end
    repeat (20) @(posedge clk);
    final_report();
  end
endmodule
